// ==== src/em_sig_pkg.sv ====
// constants, register map and state type for the e-and-m signaling emulator
package em_sig_pkg;
  // ms tick derived from the reference clock rate
  localparam int CLK_MHZ        = 250;
  localparam int US_PER_MS      = 1000;
  localparam int TICK_CYC       = CLK_MHZ * US_PER_MS;
  // supervisory and digit timing in ms
  localparam int WINK_NOM_MS    = 250;
  localparam int WINK_TOL_MS    = 50;
  localparam int WINK_MIN_MS    = WINK_NOM_MS - WINK_TOL_MS;
  localparam int WINK_MAX_MS    = WINK_NOM_MS + WINK_TOL_MS;
  localparam int IMM_DELAY_MS   = 2000;
  localparam int DTMF_TONE_MS   = 75;
  localparam int MF_TONE_MS     = 65;
  localparam int DP_PPS         = 10;
  localparam int DP_BREAK_PCT   = 60;
  localparam int PCT_SCALE      = 100;
  localparam int MS_PER_S       = 1000;
  localparam int DP_PERIOD_MS   = MS_PER_S / DP_PPS;
  localparam int DP_BREAK_MS    = DP_PERIOD_MS * DP_BREAK_PCT / PCT_SCALE;
  localparam int DP_MAKE_MS     = DP_PERIOD_MS - DP_BREAK_MS;
  localparam int DP_IDG_TX_MS   = 700;
  localparam int DP_IDG_RX_MS   = 150;
  localparam int MAX_DIGITS     = 16;
  localparam logic [3:0] DP_MAX_PULSES = 4'hA;
  // digit formats
  localparam logic [1:0] FMT_MF   = 2'h0;
  localparam logic [1:0] FMT_DTMF = 2'h1;
  localparam logic [1:0] FMT_DP   = 2'h2;
  // e-and-m types; types II to IV use the battery and ground signal leads
  localparam logic [2:0] TYPE_I   = 3'h1;
  localparam logic [2:0] TYPE_II  = 3'h2;
  localparam logic [2:0] TYPE_III = 3'h3;
  localparam logic [2:0] TYPE_IV  = 3'h4;
  // register byte offsets
  localparam int ADR_W = 9;
  localparam logic [8:0] REG_CTRL    = 9'h000;
  localparam logic [8:0] REG_STATUS  = 9'h004;
  localparam logic [8:0] REG_WINK    = 9'h008;
  localparam logic [8:0] REG_PREWINK = 9'h00C;
  localparam logic [8:0] REG_ANSWER  = 9'h010;
  localparam logic [8:0] REG_SENDCNT = 9'h014;
  localparam logic [2:0] BLK_SEND    = 3'h1;
  localparam logic [2:0] BLK_RXA     = 3'h2;
  localparam logic [2:0] BLK_RXB     = 3'h3;
  localparam logic [2:0] BLK_RXC     = 3'h4;
  // control register fields
  localparam int C_ROLE = 0;
  localparam int C_TYPE = 1;
  localparam int C_FMT  = 4;
  localparam int C_IMM  = 6;
  localparam int C_RX   = 7;
  localparam int C_ARM  = 8;
  localparam int C_ANS  = 9;
  // call sequencer states
  typedef enum logic [3:0] {
    S_IDLE, S_RX_SEIZE, S_RX_WINK, S_RX_DIG, S_TX_WWAIT, S_TX_WINK, S_TX_DELAY,
    S_TX_NEXT, S_TX_TONE, S_TX_GAP, S_TX_BREAK, S_TX_MAKE, S_TX_IDG, S_ANS_WAIT,
    S_CONNECTED
  } state_t;
endpackage

// ==== src/em_ratio_div.sv ====
// sequential restoring divider for pulse rate and percent break
`timescale 1ns/1ps
module em_ratio_div
  import em_sig_pkg::*;
#(
  parameter int NW = 24,
  parameter int DW = 16
) (
  input  wire logic          ref_clk,
  input  wire logic          reset,
  input  wire logic          start,
  input  wire logic [NW-1:0] num,
  input  wire logic [DW-1:0] den,
  output logic               done,
  output logic [NW-1:0]      quo
);
  localparam int CW = $clog2(NW + 1);
  typedef struct packed {
    logic [CW-1:0] cnt;
    logic [NW-1:0] n;
    logic [NW:0]   rem;
    logic [NW-1:0] quo;
    logic          run;
    logic          done;
  } div_t;
  div_t q;
  div_t d;
  logic [NW:0] r;

  // one quotient bit per clock, done pulses with the last bit
  always_comb begin
    d = q;
    r = '0;
    d.done = 1'b0;
    if (start) begin
      d.n = num;
      d.rem = '0;
      d.quo = '0;
      d.cnt = CW'(NW);
      d.run = 1'b1;
    end else if (q.run) begin
      r = {q.rem[NW-1:0], q.n[NW-1]};
      d.n = {q.n[NW-2:0], 1'b0};
      if (r >= (NW+1)'(den)) begin
        r = r - (NW+1)'(den);
        d.quo = {q.quo[NW-2:0], 1'b1};
      end else begin
        d.quo = {q.quo[NW-2:0], 1'b0};
      end
      d.rem = r;
      d.cnt = q.cnt - CW'(1);
      if (q.cnt == CW'(1)) begin
        d.run = 1'b0;
        d.done = 1'b1;
      end
    end
  end

  // state register
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign done = q.done;
  assign quo  = q.quo;
endmodule

// ==== src/em_did_signaling_emulator.sv ====
// e-and-m / direct inward dial supervisory signaling emulator with wishbone registers
//
// The Wishbone interface to the registers and the address map were chosen for this implementation.
`timescale 1ns/1ps
module em_did_signaling_emulator
  import em_sig_pkg::*;
#(
  parameter int TICK_CYCLES = TICK_CYC
) (
  input  wire logic        ref_clk,
  input  wire logic        reset,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [31:0] wb_adr_i,
  input  wire logic [31:0] wb_dat_i,
  input  wire logic [3:0]  wb_sel_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        eGroundIn,
  input  wire logic        mBatteryIn,
  input  wire logic        toneRxDetect,
  input  wire logic [3:0]  toneRxCode,
  output logic             mBatteryOut,
  output logic             mGroundOut,
  output logic             eGroundOut,
  output logic             signalLeadEnable,
  output logic             toneTxOn,
  output logic [3:0]       toneTxCode,
  output logic             toneTxMf
);
  localparam int TW = $clog2(TICK_CYCLES);
  typedef struct packed {
    logic [2:0]        eSync;
    logic [2:0]        mSync;
    logic              eGnd;
    logic              mBat;
    logic [TW-1:0]     tickCnt;
    logic              tick;
    logic [9:0]        ctrl;
    logic              cRole;
    logic [2:0]        cType;
    logic [1:0]        cFmt;
    logic              cImm;
    logic              cRx;
    state_t            st;
    logic [15:0]       tmr;
    logic [15:0]       phaseMs;
    logic [15:0]       wink;
    logic [15:0]       pw;
    logic [15:0]       ans;
    logic              winkOk;
    logic              ansOk;
    logic              farPrev;
    logic              toneRxPrev;
    logic [3:0]        lastCode;
    logic              inDigit;
    logic [3:0]        pulses;
    logic [15:0]       lastBrk;
    logic [15:0]       lastMk;
    logic [4:0]        sendCnt;
    logic [15:0][3:0]  sendDig;
    logic [4:0]        txIdx;
    logic [4:0]        rxCnt;
    logic [15:0][3:0]  rxDig;
    logic [15:0][7:0]  rxPct;
    logic [15:0][7:0]  rxPps;
    logic [15:0]       rxRate;
    logic [15:0]       rxIdg;
    logic [15:0][15:0] rxBrk;
    logic [15:0][15:0] rxMk;
    logic [15:0][15:0] rxGap;
    logic [1:0]        divPh;
    logic [3:0]        divIdx;
    logic              divStart;
    logic [23:0]       divNum;
    logic [15:0]       divDen;
    logic              ownOff;
    logic              mBatOut;
    logic              mGndOut;
    logic              eGndOut;
    logic              sigLeads;
    logic              toneOn;
    logic [3:0]        toneCode;
    logic              ack;
    logic [31:0]       rdat;
  } core_t;
  core_t q;
  core_t d;
  logic        divDone;
  logic [23:0] divQuo;
  logic        far;
  logic        access;
  logic [3:0]  idx;
  logic [3:0]  ri;
  logic [15:0] toneMs;
  logic [31:0] wmask;

  em_ratio_div #(.NW(24), .DW(16)) u_div (
    .ref_clk (ref_clk),
    .reset   (reset),
    .start   (q.divStart),
    .num     (q.divNum),
    .den     (q.divDen),
    .done    (divDone),
    .quo     (divQuo)
  );

  // pins, tick, bus slave and call sequencer
  always_comb begin
    d = q;
    d.divStart = 1'b0;
    d.tick = 1'b0;
    idx = q.txIdx[3:0];
    ri = q.rxCnt[3:0];
    wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
    toneMs = (q.cFmt == FMT_MF) ? 16'(MF_TONE_MS) : 16'(DTMF_TONE_MS);
    // three-stage pin synchronisers, level taken once stages two and three agree
    d.eSync = {q.eSync[1:0], eGroundIn};
    d.mSync = {q.mSync[1:0], mBatteryIn};
    if (q.eSync[2] == q.eSync[1]) d.eGnd = q.eSync[2];
    if (q.mSync[2] == q.mSync[1]) d.mBat = q.mSync[2];
    // trunk side decodes the E lead, signaling set decodes the M lead
    far = q.cRole ? q.mBat : q.eGnd;
    d.farPrev = far;
    d.toneRxPrev = toneRxDetect;
    // common millisecond tick
    if (q.tickCnt == TW'(TICK_CYCLES - 1)) begin
      d.tickCnt = '0;
      d.tick = 1'b1;
    end else begin
      d.tickCnt = q.tickCnt + TW'(1);
    end
    if (q.tick) begin
      d.tmr = q.tmr + 16'h1;
      d.phaseMs = q.phaseMs + 16'h1;
    end
    // wishbone classic slave, one wait state
    access = wb_cyc_i && wb_stb_i && !q.ack;
    d.ack = access;
    if (access && wb_we_i) begin
      if (wb_adr_i[ADR_W-1:0] == REG_CTRL) begin
        d.ctrl = 10'((32'(q.ctrl) & ~wmask) | (wb_dat_i & wmask));
      end else if (wb_adr_i[ADR_W-1:0] == REG_SENDCNT && wb_sel_i[0]) begin
        d.sendCnt = (wb_dat_i[4:0] > 5'(MAX_DIGITS)) ? 5'(MAX_DIGITS) : wb_dat_i[4:0];
      end else if (wb_adr_i[ADR_W-1:6] == BLK_SEND && wb_sel_i[0]) begin
        d.sendDig[wb_adr_i[5:2]] = wb_dat_i[3:0];
      end
    end
    if (access && !wb_we_i) begin
      d.rdat = '0;
      if (wb_adr_i[ADR_W-1:0] == REG_CTRL) begin
        d.rdat = 32'(q.ctrl);
      end else if (wb_adr_i[ADR_W-1:0] == REG_STATUS) begin
        d.rdat = {15'h0, q.ansOk, q.winkOk, q.ownOff, far, q.rxCnt, 4'h0, q.st};
      end else if (wb_adr_i[ADR_W-1:0] == REG_WINK) begin
        d.rdat = {16'h0, q.wink};
      end else if (wb_adr_i[ADR_W-1:0] == REG_PREWINK) begin
        d.rdat = {16'h0, q.pw};
      end else if (wb_adr_i[ADR_W-1:0] == REG_ANSWER) begin
        d.rdat = {16'h0, q.ans};
      end else if (wb_adr_i[ADR_W-1:0] == REG_SENDCNT) begin
        d.rdat = {27'h0, q.sendCnt};
      end else if (wb_adr_i[ADR_W-1:6] == BLK_SEND) begin
        d.rdat = {28'h0, q.sendDig[wb_adr_i[5:2]]};
      end else if (wb_adr_i[ADR_W-1:6] == BLK_RXA) begin
        d.rdat = {10'h0, q.rxIdg[wb_adr_i[5:2]], q.rxRate[wb_adr_i[5:2]],
                  q.rxPps[wb_adr_i[5:2]], q.rxPct[wb_adr_i[5:2]], q.rxDig[wb_adr_i[5:2]]};
      end else if (wb_adr_i[ADR_W-1:6] == BLK_RXB) begin
        d.rdat = {q.rxMk[wb_adr_i[5:2]], q.rxBrk[wb_adr_i[5:2]]};
      end else if (wb_adr_i[ADR_W-1:6] == BLK_RXC) begin
        d.rdat = {16'h0, q.rxGap[wb_adr_i[5:2]]};
      end
    end
    // ratio results: percent break first, then pulses per second
    if (divDone && q.divPh == 2'h1) begin
      d.rxPct[q.divIdx] = divQuo[7:0];
      d.divPh = 2'h2;
      d.divNum = 24'(MS_PER_S);
      d.divStart = 1'b1;
    end else if (divDone && q.divPh == 2'h2) begin
      d.rxPps[q.divIdx] = divQuo[7:0];
      d.divPh = 2'h0;
    end
    // call sequencer
    case (q.st)
      S_IDLE: begin
        d.ownOff = 1'b0;
        d.toneOn = 1'b0;
        d.cRole = q.ctrl[C_ROLE];
        d.cType = q.ctrl[C_TYPE +: 3];
        d.cFmt = q.ctrl[C_FMT +: 2];
        d.cImm = q.ctrl[C_IMM];
        d.cRx = q.ctrl[C_RX];
        if (q.ctrl[C_ARM]) begin
          d.wink = '0;
          d.pw = '0;
          d.ans = '0;
          d.winkOk = 1'b0;
          d.ansOk = 1'b0;
          d.rxCnt = '0;
          d.rxIdg = '0;
          d.rxRate = '0;
          d.txIdx = '0;
          d.inDigit = 1'b0;
          d.tmr = '0;
          if (q.ctrl[C_RX]) begin
            d.st = S_RX_SEIZE;
          end else begin
            d.ownOff = 1'b1;
            d.st = q.ctrl[C_IMM] ? S_TX_DELAY : S_TX_WWAIT;
          end
        end
      end
      S_RX_SEIZE: begin
        if (far) begin
          d.tmr = '0;
          d.phaseMs = '0;
          d.ownOff = !q.cImm;
          d.st = q.cImm ? S_RX_DIG : S_RX_WINK;
        end
      end
      S_RX_WINK: begin
        if (d.tmr >= 16'(WINK_NOM_MS)) begin
          d.ownOff = 1'b0;
          d.phaseMs = '0;
          d.st = S_RX_DIG;
        end
      end
      S_RX_DIG: begin
        d.ownOff = q.ctrl[C_ANS];
        if (q.rxCnt < 5'(MAX_DIGITS)) begin
          if (q.cFmt == FMT_DP) begin
            // pulses arrive on the far lead; a break is the far end going on-hook
            if (q.farPrev && !far) begin
              if (q.inDigit) begin
                d.lastMk = q.phaseMs;
              end else begin
                if (q.rxCnt != 5'h0) begin
                  d.rxGap[ri - 4'h1] = q.phaseMs;
                  d.rxIdg[ri - 4'h1] = 1'b1;
                end
                d.inDigit = 1'b1;
                d.pulses = '0;
              end
              d.phaseMs = '0;
            end else if (!q.farPrev && far && q.inDigit) begin
              d.lastBrk = q.phaseMs;
              d.pulses = q.pulses + 4'h1;
              d.phaseMs = '0;
            end else if (q.inDigit && far && q.phaseMs >= 16'(DP_IDG_RX_MS)) begin
              d.inDigit = 1'b0;
              d.rxDig[ri] = (q.pulses >= DP_MAX_PULSES) ? 4'h0 : q.pulses;
              d.rxBrk[ri] = q.lastBrk;
              d.rxMk[ri] = (q.pulses > 4'h1) ? q.lastMk : 16'h0;
              d.rxPct[ri] = '0;
              d.rxPps[ri] = '0;
              d.rxRate[ri] = q.pulses > 4'h1;
              if (q.pulses > 4'h1) begin
                d.divIdx = ri;
                d.divPh = 2'h1;
                d.divNum = 24'(q.lastBrk * PCT_SCALE);
                d.divDen = 16'(q.lastBrk + q.lastMk);
                d.divStart = 1'b1;
              end
              d.rxCnt = q.rxCnt + 5'h1;
            end
          end else begin
            // tone digits come from the tip-ring detector
            if (toneRxDetect && !q.toneRxPrev) begin
              if (q.rxCnt != 5'h0) begin
                d.rxGap[ri - 4'h1] = q.phaseMs;
                d.rxIdg[ri - 4'h1] = 1'b1;
              end
              d.lastCode = toneRxCode;
              d.phaseMs = '0;
            end else if (!toneRxDetect && q.toneRxPrev) begin
              d.rxDig[ri] = q.lastCode;
              d.rxBrk[ri] = q.phaseMs;
              d.rxMk[ri] = '0;
              d.rxRate[ri] = 1'b0;
              d.phaseMs = '0;
              d.rxCnt = q.rxCnt + 5'h1;
            end
          end
        end
      end
      S_TX_WWAIT: begin
        if (q.tick) d.pw = q.pw + 16'h1;
        if (far) begin
          d.tmr = '0;
          d.st = S_TX_WINK;
        end
      end
      S_TX_WINK: begin
        if (q.tick) d.pw = q.pw + 16'h1;
        if (!far) begin
          if (q.tmr >= 16'(WINK_MIN_MS) && q.tmr <= 16'(WINK_MAX_MS)) begin
            d.wink = q.tmr;
            d.pw = q.pw - q.tmr;
            d.winkOk = 1'b1;
            d.st = S_TX_NEXT;
          end else begin
            d.st = S_TX_WWAIT;
          end
        end
      end
      S_TX_DELAY: begin
        if (d.tmr >= 16'(IMM_DELAY_MS)) d.st = S_TX_NEXT;
      end
      S_TX_NEXT: begin
        d.tmr = '0;
        if (q.txIdx >= q.sendCnt) begin
          d.ans = '0;
          d.st = S_ANS_WAIT;
        end else if (q.cFmt == FMT_DP) begin
          d.pulses = (q.sendDig[idx] == 4'h0 || q.sendDig[idx] > DP_MAX_PULSES) ?
                     DP_MAX_PULSES : q.sendDig[idx];
          d.ownOff = 1'b0;
          d.st = S_TX_BREAK;
        end else begin
          d.toneOn = 1'b1;
          d.toneCode = q.sendDig[idx];
          d.st = S_TX_TONE;
        end
      end
      S_TX_TONE: begin
        if (d.tmr >= toneMs) begin
          d.toneOn = 1'b0;
          d.tmr = '0;
          d.txIdx = q.txIdx + 5'h1;
          d.ans = '0;
          d.st = (q.txIdx + 5'h1 >= q.sendCnt) ? S_ANS_WAIT : S_TX_GAP;
        end
      end
      S_TX_GAP: begin
        if (d.tmr >= toneMs) d.st = S_TX_NEXT;
      end
      S_TX_BREAK: begin
        if (d.tmr >= 16'(DP_BREAK_MS)) begin
          d.ownOff = 1'b1;
          d.tmr = '0;
          d.pulses = q.pulses - 4'h1;
          if (q.pulses == 4'h1) begin
            d.txIdx = q.txIdx + 5'h1;
            d.ans = '0;
            d.st = (q.txIdx + 5'h1 >= q.sendCnt) ? S_ANS_WAIT : S_TX_IDG;
          end else begin
            d.st = S_TX_MAKE;
          end
        end
      end
      S_TX_MAKE: begin
        if (d.tmr >= 16'(DP_MAKE_MS)) begin
          d.ownOff = 1'b0;
          d.tmr = '0;
          d.st = S_TX_BREAK;
        end
      end
      S_TX_IDG: begin
        if (d.tmr >= 16'(DP_IDG_TX_MS)) d.st = S_TX_NEXT;
      end
      S_ANS_WAIT: begin
        if (q.tick) d.ans = q.ans + 16'h1;
        if (far) begin
          d.ansOk = 1'b1;
          d.st = S_CONNECTED;
        end
      end
      default: begin
      end
    endcase
    if (q.st != S_IDLE && !q.ctrl[C_ARM]) begin
      d.st = S_IDLE;
      d.ownOff = 1'b0;
      d.toneOn = 1'b0;
    end
    // lead drive per role and type
    d.mBatOut = !d.cRole && d.ownOff;
    d.mGndOut = !d.cRole && !d.ownOff && (d.cType == TYPE_I || d.cType == TYPE_III);
    d.eGndOut = d.cRole && d.ownOff;
    d.sigLeads = d.cType >= TYPE_II && d.cType <= TYPE_IV;
  end

  // state register
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign wb_dat_o         = q.rdat;
  assign wb_ack_o         = q.ack;
  assign mBatteryOut      = q.mBatOut;
  assign mGroundOut       = q.mGndOut;
  assign eGroundOut       = q.eGndOut;
  assign signalLeadEnable = q.sigLeads;
  assign toneTxOn         = q.toneOn;
  assign toneTxCode       = q.toneCode;
  assign toneTxMf         = q.cFmt == FMT_MF;
endmodule

// ==== bench/em_sig_assertions.sv ====
// port-level checks on the signaling emulator
`timescale 1ns/1ps
module em_sig_checker #(
  parameter int TICK_CYCLES = 10
) (
  input wire logic       ref_clk,
  input wire logic       reset,
  input wire logic       wb_cyc_i,
  input wire logic       wb_stb_i,
  input wire logic       wb_ack_o,
  input wire logic       mBatteryOut,
  input wire logic       mGroundOut,
  input wire logic       eGroundOut,
  input wire logic       toneTxOn,
  input wire logic [3:0] toneTxCode,
  input wire logic       toneTxMf
);
  localparam int T = TICK_CYCLES;
  logic [31:0] toneLen_q;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);
  // cycles the current tone has been on
  always_ff @(posedge ref_clk) begin
    toneLen_q <= (reset || !toneTxOn) ? 32'h0 : toneLen_q + 32'h1;
  end
  ack_latency_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("request not answered next cycle");
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  ack_idle_a: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
    else $error("ack without request");
  m_lead_a: assert property (!(mBatteryOut && mGroundOut))
    else $error("battery and ground on M together");
  role_lead_a: assert property (!(eGroundOut && (mBatteryOut || mGroundOut)))
    else $error("both leads driven");
  tone_hook_a: assert property (toneTxOn |-> mBatteryOut || eGroundOut)
    else $error("tone while on-hook");
  tone_code_a: assert property (toneTxOn && $past(toneTxOn) |-> $stable(toneTxCode))
    else $error("tone code changed mid-tone");
  tone_fmt_a: assert property (toneTxOn |-> $stable(toneTxMf))
    else $error("tone format changed");
  tone_len_a: assert property ($fell(toneTxOn) && (mBatteryOut || eGroundOut) |->
    toneLen_q >= (toneTxMf ? 64 : 74) * T && toneLen_q <= (toneTxMf ? 66 : 76) * T)
    else $error("tone length wrong");
endmodule

bind em_did_signaling_emulator em_sig_checker #(.TICK_CYCLES(TICK_CYCLES)) u_chk (
  .ref_clk(ref_clk), .reset(reset), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_ack_o(wb_ack_o), .mBatteryOut(mBatteryOut), .mGroundOut(mGroundOut),
  .eGroundOut(eGroundOut), .toneTxOn(toneTxOn), .toneTxCode(toneTxCode), .toneTxMf(toneTxMf)
);

// ==== bench/em_far_end.sv ====
// far-end trunk or signaling set across the e-and-m leads
`timescale 1ns/1ps
module em_far_end #(
  parameter int T = 10
) (
  input  wire logic  ref_clk,
  output logic       farOff,
  output logic       toneOn,
  output logic [3:0] toneCode
);
  initial begin
    farOff = 1'b0;
    toneOn = 1'b0;
    toneCode = 4'hF;
  end
  // hold the far hook state for some ms: battery on M or ground on E
  task automatic level(input logic v, input int ms);
    farOff <= v;
    repeat (ms * T) @(posedge ref_clk);
  endtask
  // off-hook pulse of the given length, then back on-hook
  task automatic wink(input int ms);
    level(1'b1, ms);
    farOff <= 1'b0;
  endtask
  // one detected tone digit; code goes stale-inverted between digits
  task automatic tone(input logic [3:0] c, input int ms);
    toneCode <= c;
    toneOn <= 1'b1;
    repeat (ms * T) @(posedge ref_clk);
    toneOn <= 1'b0;
    toneCode <= ~c;
    repeat (ms * T) @(posedge ref_clk);
  endtask
endmodule

// ==== bench/em_did_signaling_emulator_test.sv ====
// self-checking bench for the signaling emulator
`timescale 1ns/1ps
module em_did_signaling_emulator_test
  import em_sig_pkg::*;
;
  localparam int T = 10;
  logic        ref_clk = 1'b0;
  logic        reset = 1'b1;
  logic        wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [31:0] wb_adr_i = 32'h0, wb_dat_i = 32'h0, wb_dat_o, rd;
  logic        wb_ack_o, roleSig = 1'b0, farOff, toneRxDetect, toneTxOn, toneTxMf;
  logic [3:0]  toneRxCode, toneTxCode;
  logic        mBatteryOut, mGroundOut, eGroundOut, signalLeadEnable;
  int          nErrors = 0, comparisons = 0, cycles = 0, n;

  // far side feeds the lead that its role senses
  em_did_signaling_emulator #(.TICK_CYCLES(T)) u_dut (
    .ref_clk(ref_clk), .reset(reset), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_sel_i(4'hF),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .eGroundIn(farOff & !roleSig),
    .mBatteryIn(farOff & roleSig), .toneRxDetect(toneRxDetect), .toneRxCode(toneRxCode),
    .mBatteryOut(mBatteryOut), .mGroundOut(mGroundOut), .eGroundOut(eGroundOut),
    .signalLeadEnable(signalLeadEnable), .toneTxOn(toneTxOn), .toneTxCode(toneTxCode),
    .toneTxMf(toneTxMf)
  );
  em_far_end #(.T(T)) u_far (
    .ref_clk(ref_clk), .farOff(farOff), .toneOn(toneRxDetect), .toneCode(toneRxCode)
  );

  // clock and hang guard
  always #2 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 60000) begin
      nErrors++;
      end_sim();
    end
  end

  task automatic end_sim();
    if (nErrors == 0 && comparisons > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e, input int tol = 0);
    comparisons++;
    if ($isunknown(g) || g + tol < e || g > e + tol) begin
      nErrors++;
      $display("Error %0t: got %0h expected %0h", $time, g, e);
    end
  endtask

  // one classic wishbone cycle; read data lands in rd
  task automatic wb(input logic we, input logic [8:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge ref_clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= {23'h0, a};
    wb_dat_i <= d;
    @(posedge ref_clk);
    while (wb_ack_o !== 1'b1 && k < 50) begin
      @(posedge ref_clk);
      k++;
    end
    if (wb_ack_o !== 1'b1) begin
      nErrors++;
      $display("Error %0t: no bus ack", $time);
    end
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
  endtask

  task automatic rdchk(input logic [8:0] a, input logic [31:0] e, input int tol = 0);
    wb(1'b0, a, 32'h0);
    chk(rd, e, tol);
  endtask

  // count cycles until a watched output reaches v
  task automatic waitSig(input int s, input logic v, input int max);
    n = 0;
    while ((s == 0 ? toneTxOn : s == 1 ? mBatteryOut : eGroundOut) !== v && n < max) begin
      @(posedge ref_clk);
      n++;
    end
    if (n >= max) begin
      nErrors++;
      $display("Error %0t: wait timed out", $time);
    end
  endtask

  task automatic scenRegs();
    chk({mBatteryOut, eGroundOut, toneTxOn, wb_ack_o}, 0);
    rdchk(REG_CTRL, 0);
    rdchk(REG_STATUS, 0);
    wb(1'b1, 9'h1F0, 32'hFFFF);
    rdchk(9'h1F0, 0);
    wb(1'b1, REG_SENDCNT, 32'h11);
    rdchk(REG_SENDCNT, 16);
  endtask

  task automatic scenWinkDtmf();
    roleSig <= 1'b0;
    wb(1'b1, REG_SENDCNT, 32'h2);
    wb(1'b1, 9'h040, 32'h3);
    wb(1'b1, 9'h044, 32'hB);
    wb(1'b1, REG_CTRL, 32'h112);
    waitSig(1, 1'b1, 20);
    chk(mGroundOut, 0);
    u_far.level(1'b0, 50);
    u_far.wink(250);
    waitSig(0, 1'b1, 20 * T);
    chk({toneTxMf, toneTxCode}, 5'h03);
    waitSig(0, 1'b0, 100 * T);
    chk(n, 75 * T, 20);
    waitSig(0, 1'b1, 100 * T);
    chk(n, 75 * T, 20);
    chk(toneTxCode, 4'hB);
    waitSig(0, 1'b0, 100 * T);
    u_far.level(1'b0, 100);
    u_far.level(1'b1, 10);
    rdchk(REG_WINK, 250, 1);
    rdchk(REG_PREWINK, 50, 2);
    rdchk(REG_ANSWER, 100, 2);
    wb(1'b0, REG_STATUS, 32'h0);
    chk(rd[16:15], 2'h3);
    wb(1'b1, REG_CTRL, 32'h012);
    u_far.level(1'b0, 2);
    chk({mBatteryOut, mGroundOut}, 2'h1);
  endtask

  task automatic scenImmMf();
    roleSig <= 1'b1;
    wb(1'b1, REG_SENDCNT, 32'h1);
    wb(1'b1, 9'h040, 32'hA);
    wb(1'b1, REG_CTRL, 32'h145);
    waitSig(2, 1'b1, 20);
    chk({signalLeadEnable, mBatteryOut}, 2'h2);
    waitSig(0, 1'b1, 2100 * T);
    chk(n, 2000 * T, 2 * T);
    chk({toneTxMf, toneTxCode}, 5'h1A);
    waitSig(0, 1'b0, 100 * T);
    chk(n, 65 * T, 20);
    u_far.level(1'b0, 30);
    u_far.level(1'b1, 10);
    rdchk(REG_WINK, 0);
    rdchk(REG_PREWINK, 0);
    rdchk(REG_ANSWER, 30, 2);
    wb(1'b1, REG_CTRL, 32'h045);
    u_far.level(1'b0, 2);
    chk(eGroundOut, 0);
  endtask

  task automatic scenPulse();
    roleSig <= 1'b0;
    wb(1'b1, REG_SENDCNT, 32'h1);
    wb(1'b1, 9'h040, 32'h2);
    wb(1'b1, REG_CTRL, 32'h12A);
    waitSig(1, 1'b1, 20);
    u_far.wink(100);
    repeat (50 * T) @(posedge ref_clk);
    chk(mBatteryOut, 1);
    u_far.wink(250);
    waitSig(1, 1'b0, 20 * T);
    waitSig(1, 1'b1, 100 * T);
    chk(n, 60 * T, 20);
    waitSig(1, 1'b0, 100 * T);
    chk(n, 40 * T, 20);
    chk(toneTxOn, 0);
    rdchk(REG_PREWINK, 150, 2);
    wb(1'b1, REG_CTRL, 32'h02A);
    u_far.level(1'b0, 2);
    chk({mBatteryOut, mGroundOut}, 2'h0);
  endtask

  task automatic scenReceive();
    wb(1'b1, REG_CTRL, 32'h192);
    u_far.level(1'b1, 0);
    waitSig(1, 1'b1, 20 * T);
    waitSig(1, 1'b0, 300 * T);
    chk(n, 250 * T, 20);
    u_far.tone(4'h7, 40);
    u_far.tone(4'h9, 40);
    wb(1'b0, 9'h080, 32'h0);
    chk(rd[3:0], 4'h7);
    wb(1'b0, 9'h084, 32'h0);
    chk(rd[3:0], 4'h9);
    wb(1'b0, 9'h0C0, 32'h0);
    chk(rd[15:0], 40, 1);
    wb(1'b0, REG_STATUS, 32'h0);
    chk(rd[12:8], 5'h02);
    wb(1'b1, REG_CTRL, 32'h092);
    u_far.level(1'b0, 2);
  endtask

  // far end dials a two then a one with dial pulses, immediate start
  task automatic scenPulseRx();
    wb(1'b1, REG_CTRL, 32'h1E2);
    u_far.level(1'b1, 20);
    u_far.level(1'b0, 60);
    u_far.level(1'b1, 40);
    u_far.level(1'b0, 60);
    u_far.level(1'b1, 200);
    u_far.level(1'b0, 60);
    u_far.level(1'b1, 200);
    wb(1'b0, 9'h080, 32'h0);
    chk({rd[21:20], rd[3:0]}, 6'h32);
    chk(rd[11:4], 60, 1);
    chk(rd[19:12], 10);
    wb(1'b0, 9'h084, 32'h0);
    chk(rd[21:0], 22'h1);
    wb(1'b0, 9'h0C0, 32'h0);
    chk(rd[15:0], 60, 1);
    chk(rd[31:16], 40, 1);
    wb(1'b0, 9'h0C4, 32'h0);
    chk(rd[31:16], 0);
    wb(1'b0, 9'h100, 32'h0);
    chk(rd[15:0], 200, 1);
  endtask

  initial begin
    repeat (6) @(posedge ref_clk);
    reset <= 1'b0;
    scenRegs();
    scenWinkDtmf();
    scenImmMf();
    scenPulse();
    scenReceive();
    scenPulseRx();
    end_sim();
  end
endmodule
